// ===== rtl/dff_pkg.sv
// Purpose: shared constants and types for the display frame fetch engine
// Assumes: 32-bit AHB-Lite register slave, one clock
// Notes:   register byte offsets, field positions, reset values
package dff_pkg;
    localparam logic [7:0]  DFF_OFS_CTRL   = 8'h00;
    localparam logic [7:0]  DFF_OFS_CFG    = 8'h04;
    localparam logic [7:0]  DFF_OFS_BASE   = 8'h08;
    localparam logic [7:0]  DFF_OFS_SIZE   = 8'h0C;
    localparam logic [7:0]  DFF_OFS_STAT   = 8'h10;
    localparam logic [7:0]  DFF_OFS_IRQS   = 8'h14;
    localparam logic [7:0]  DFF_OFS_IRQM   = 8'h18;
    localparam logic [7:0]  DFF_OFS_ADDR   = 8'h1C;
    // control bits
    localparam int DFF_CTRL_EN     = 0;
    localparam int DFF_CTRL_PWR    = 1;
    localparam int DFF_CTRL_RST    = 2;
    // config fields
    localparam int DFF_CFG_BLEN_LO = 0;
    localparam int DFF_CFG_PACK    = 8;
    // status bits
    localparam int DFF_ST_ACTIVE   = 0;
    localparam int DFF_ST_EMPTY    = 1;
    localparam int DFF_ST_FULL     = 2;
    // interrupt bits
    localparam int DFF_IRQ_UNDER   = 0;
    localparam int DFF_IRQ_FRAME   = 1;
    localparam int DFF_IRQ_XERR    = 2;
    localparam int DFF_IRQ_W       = 3;
    localparam logic [31:0] DFF_RST_CFG  = 32'h0000_000F;
    localparam logic [31:0] DFF_RST_ZERO = 32'h0000_0000;
    // 1-Kbyte boundary: low ten address bits
    localparam int DFF_KB_BITS     = 10;
    localparam int DFF_BLEN_W      = 5;

    typedef struct packed {
        logic        req;
        logic [31:0] addr;
        logic        last;
    } dff_mreq_t;

    typedef struct packed {
        logic        en;
        logic        pwr;
        logic [3:0]  blen;
        logic        pack;
        logic [31:0] base;
        logic [23:0] words;
    } dff_cfg_t;
endpackage

// ===== rtl/dff_fifo_mem.sv
// Purpose: display fifo storage with registered read data
// Assumes: one write port, one read port, same clock
// Notes:   pointers live in the caller so power-off can clear them
`timescale 1ns/100ps
`default_nettype none
module dff_fifo_mem #(
    parameter int AW = 5,
    parameter int DW = 32
) (
    input  wire logic          hclk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic          re,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // no reset on the array; read data only valid after a read strobe
    always_ff @(posedge hclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

// ===== rtl/dff_fetch.sv
// Purpose: display frame fetch engine with display fifo
// Assumes: one memory read channel, request/grant with data valid
// Notes:   software registers over AHB-Lite, one level interrupt
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module dff_fetch
    import dff_pkg::*;
#(
    parameter int FIFO_AW = 5
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             irq,
    output logic             mem_req,
    output logic [31:0]      mem_addr,
    input  wire logic        mem_gnt,
    input  wire logic        mem_rvalid,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        pix_rd,
    output logic [31:0]      pix_data,
    output logic             fetch_active_flag
);
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_REQ   = 3'b010,
        ST_DATA  = 3'b100
    } dff_st_t;

    localparam int DEPTH = 1 << FIFO_AW;

    dff_cfg_t            cfg_q;
    logic [31:0]         base_q;
    logic [23:0]         words_q;
    logic [DFF_IRQ_W-1:0] irqs_q, irqm_q;
    logic                bus_act_q, bus_wr_q;
    logic [7:0]          bus_ofs_q;
    dff_st_t             st_q;
    logic [31:0]         addr_q;
    logic [23:0]         left_q;
    logic [DFF_BLEN_W-1:0] beat_q, burst_q;
    logic [FIFO_AW:0]    wptr_q, rptr_q, resv_q;
    logic                en_q, pwr_q;

    // ahb decode
    wire bus_take  = hsel & hready & htrans[1];
    wire wr_go     = bus_act_q & bus_wr_q;
    wire wr_ctrl   = wr_go & (bus_ofs_q == DFF_OFS_CTRL);
    wire wr_cfg    = wr_go & (bus_ofs_q == DFF_OFS_CFG);
    wire wr_base   = wr_go & (bus_ofs_q == DFF_OFS_BASE);
    wire wr_size   = wr_go & (bus_ofs_q == DFF_OFS_SIZE);
    wire wr_irqs   = wr_go & (bus_ofs_q == DFF_OFS_IRQS);
    wire wr_irqm   = wr_go & (bus_ofs_q == DFF_OFS_IRQM);
    wire sw_rst    = wr_ctrl & hwdata[DFF_CTRL_RST];

    // fifo state
    wire [FIFO_AW:0] used  = wptr_q - rptr_q;
    wire [FIFO_AW:0] rsvd  = resv_q - rptr_q;
    wire fifo_empty = (used == '0);
    wire fifo_full  = (used[FIFO_AW] == 1'b1);
    wire underflow  = pix_rd & fifo_empty & pwr_q;
    wire pop        = pix_rd & ~fifo_empty & pwr_q;

    // burst length and 1-Kbyte clip
    wire [DFF_BLEN_W-1:0] blen_words =
        {1'b0, cfg_q.blen} + 5'd1;
    wire [DFF_KB_BITS-1:0] kb_off = addr_q[DFF_KB_BITS-1:0];
    wire [DFF_KB_BITS:0] kb_room =
        11'd1024 - {1'b0, kb_off};
    wire [DFF_KB_BITS:0] kb_words = kb_room >> 2;
    wire [DFF_BLEN_W-1:0] b1 = (kb_words < {6'd0, blen_words})
        ? kb_words[DFF_BLEN_W-1:0] : blen_words;
    wire [DFF_BLEN_W-1:0] b2 = (left_q < {19'd0, b1})
        ? left_q[DFF_BLEN_W-1:0] : b1;
    // whole burst must fit behind the words already reserved
    wire room_ok =
        ({1'b0, rsvd} + {{(FIFO_AW-3){1'b0}}, b2} <= DEPTH[FIFO_AW+1:0]);
    // a reset write in the same cycle wins, or the reserve would leak
    wire start  = en_q & ~sw_rst & (st_q == ST_IDLE) & (left_q != '0) &
        room_ok;
    wire beat   = (st_q == ST_DATA) & mem_rvalid;
    wire last_b = beat & (beat_q == burst_q - 5'd1);

    // fifo memory with registered read port
    dff_fifo_mem #(.AW(FIFO_AW), .DW(32)) u_mem (
        .hclk  (hclk),
        .we    (beat),
        .waddr (wptr_q[FIFO_AW-1:0]),
        .wdata (mem_rdata),
        .re    (pop),
        .raddr (rptr_q[FIFO_AW-1:0]),
        .rdata (pix_data)
    );

    // ahb address phase capture; slave is always zero-wait
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_act_q <= 1'b0;
            bus_wr_q  <= 1'b0;
            bus_ofs_q <= 8'h00;
        end else if (hready) begin
            bus_act_q <= bus_take;
            bus_wr_q  <= hwrite;
            bus_ofs_q <= haddr[7:0];
        end
    end

    // software registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_q    <= 1'b0;
            pwr_q   <= 1'b0;
            cfg_q      <= '0;
            cfg_q.blen <= DFF_RST_CFG[DFF_CFG_BLEN_LO +: 4];
            cfg_q.pack <= DFF_RST_CFG[DFF_CFG_PACK];
            base_q  <= DFF_RST_ZERO;
            words_q <= 24'h00_0000;
            irqm_q  <= '0;
        end else begin
            if (wr_ctrl) begin
                en_q  <= hwdata[DFF_CTRL_EN];
                pwr_q <= hwdata[DFF_CTRL_PWR];
            end
            if (wr_cfg) begin
                cfg_q.blen <= hwdata[DFF_CFG_BLEN_LO +: 4];
                cfg_q.pack <= hwdata[DFF_CFG_PACK];
            end
            if (wr_base) begin
                base_q <= hwdata;  // software aligns
            end
            if (wr_size) begin
                words_q <= hwdata[23:0];
            end
            if (wr_irqm) begin
                irqm_q <= hwdata[DFF_IRQ_W-1:0];
            end
        end
    end

    // sticky events; a new event wins over a write-one clear
    wire [DFF_IRQ_W-1:0] ev = {1'b0, last_b & (left_q == 24'd1), underflow};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irqs_q <= '0;
        end else begin
            irqs_q <= (irqs_q & ~({DFF_IRQ_W{wr_irqs}} &
                hwdata[DFF_IRQ_W-1:0])) | ev;
        end
    end
    assign irq = |(irqs_q & irqm_q);

    // fetch sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q    <= ST_IDLE;
            addr_q  <= 32'h0000_0000;
            left_q  <= 24'h00_0000;
            beat_q  <= '0;
            burst_q <= '0;
        end else if (sw_rst || (!en_q && st_q == ST_IDLE)) begin
            // disabled while idle or reset reloads the frame start; pack mode
            // fetches from base as given, so a misaligned base shifts
            // colours
            st_q   <= ST_IDLE;
            addr_q <= base_q;
            left_q <= words_q;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (start) begin
                        burst_q <= b2;
                        beat_q  <= '0;
                        st_q    <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    if (mem_gnt) begin
                        st_q <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (beat) begin
                        beat_q <= beat_q + 5'd1;
                        addr_q <= addr_q + 32'd4;
                        left_q <= left_q - 24'd1;
                    end
                    if (last_b) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // fifo pointers: only power-off clears them, not fetch reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wptr_q <= '0;
            rptr_q <= '0;
            resv_q <= '0;
        end else if (!pwr_q) begin
            wptr_q <= '0;
            rptr_q <= '0;
            resv_q <= '0;
        end else begin
            if (beat) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q <= rptr_q + 1'b1;
            end
            if (start) begin
                resv_q <= resv_q + {{(FIFO_AW-4){1'b0}}, b2};
            end
        end
    end

    // outputs
    assign mem_req   = (st_q == ST_REQ);
    assign mem_addr  = addr_q;
    assign fetch_active_flag = (st_q != ST_IDLE);
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // read mux; unmapped offsets read zero
    always_comb begin
        hrdata = 32'h0000_0000;
        case (bus_ofs_q)
            DFF_OFS_CTRL: hrdata = {30'd0, pwr_q, en_q};
            DFF_OFS_CFG:  hrdata = {23'd0, cfg_q.pack, 4'd0, cfg_q.blen};
            DFF_OFS_BASE: hrdata = base_q;
            DFF_OFS_SIZE: hrdata = {8'd0, words_q};
            DFF_OFS_STAT: hrdata = {29'd0, fifo_full, fifo_empty,
                                    fetch_active_flag};
            DFF_OFS_IRQS: hrdata = {29'd0, irqs_q};
            DFF_OFS_IRQM: hrdata = {29'd0, irqm_q};
            DFF_OFS_ADDR: hrdata = addr_q;
            default:      hrdata = 32'h0000_0000;
        endcase
    end
endmodule
`default_nettype wire

// ===== verification/dff_fetch_sva.sv
// Purpose: port-level checks for the frame fetch engine
// Assumes: one clock, async active-low reset
// Notes:   bound into every dff_fetch instance
`timescale 1ns/100ps
`default_nettype none
module dff_fetch_sva
    import dff_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        irq,
    input wire logic        mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic        mem_gnt,
    input wire logic        pix_rd,
    input wire logic        fetch_active_flag
);
    default clocking dcb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // slave answers at once and always okay
    a_ready_high: assert property (hreadyout)
        else $error("hreadyout low");
    a_resp_okay: assert property (!hresp)
        else $error("hresp not okay");
    // a burst request is held whole until the grant
    a_req_hold: assert property (mem_req && !mem_gnt |=> mem_req)
        else $error("mem_req dropped before grant");
    a_addr_hold: assert property (mem_req && !mem_gnt |=>
        $stable(mem_addr))
        else $error("mem_addr moved before grant");
    a_addr_word: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
        else $error("mem_addr not word aligned");
    // beats follow a grant, so no new request on the next cycle
    a_one_grant: assert property (mem_req && mem_gnt |=> !mem_req)
        else $error("request repeated after grant");
    a_busy_shown: assert property (mem_req && mem_gnt |=>
        fetch_active_flag)
        else $error("activity flag low during burst");
    a_idle_rst: assert property (!$past(hresetn) |->
        !mem_req && !fetch_active_flag && !irq)
        else $error("outputs active right after reset");

    c_grant: cover property (mem_req && mem_gnt);
    c_pop: cover property (pix_rd);
    c_irq: cover property (irq);
endmodule
bind dff_fetch dff_fetch_sva u_sva (.hclk, .hresetn, .hreadyout, .hresp,
    .irq, .mem_req, .mem_addr, .mem_gnt, .pix_rd, .fetch_active_flag);
`default_nettype wire

// ===== verification/dff_mem_model.sv
// Purpose: system memory answering frame fetch bursts
// Assumes: bench tells the burst field; frame size is a burst multiple
// Notes:   each data word equals its own byte address
`timescale 1ns/100ps
`default_nettype none
module dff_mem_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    input  wire logic [3:0]  blen,
    input  wire logic [3:0]  slow,
    output logic             mem_gnt,
    output logic             mem_rvalid,
    output logic [31:0]      mem_rdata
);
    logic [31:0] a_q;
    logic [8:0]  n_q;
    logic [3:0]  w_q;
    logic [10:0] room;
    logic [8:0]  want;
    // bytes left before the next 1-Kbyte line, and words asked for
    assign room = 11'h400 - {1'b0, mem_addr[9:0]};
    assign want = {5'h0, blen} + 9'h001;
    // grant after slow cycles; idle data toggles so stale words never match
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_gnt <= 1'b0;
            mem_rvalid <= 1'b0;
            mem_rdata <= 32'h0;
            a_q <= 32'h0;
            n_q <= 9'h000;
            w_q <= 4'h0;
        end else begin
            mem_gnt <= 1'b0;
            mem_rvalid <= 1'b0;
            mem_rdata <= ~mem_rdata;
            w_q <= mem_req ? w_q + 4'h1 : 4'h0;
            if (mem_req && mem_gnt) begin
                a_q <= mem_addr;
                n_q <= (room[10:2] < want) ? room[10:2] : want;
            end else if (n_q != 9'h000) begin
                mem_rvalid <= 1'b1;
                mem_rdata <= a_q;
                a_q <= a_q + 32'h4;
                n_q <= n_q - 9'h001;
            end else if (mem_req && w_q >= slow) begin
                mem_gnt <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verification/test_display_frame_fetch_dma.sv
// Purpose: register-driven test of the frame fetch engine
// Assumes: zero-wait AHB-Lite slave, memory model on the far side
// Notes:   pixel words carry their own address, so order shows
`timescale 1ns/100ps
`default_nettype none
module test_display_frame_fetch_dma import dff_pkg::*;;
    logic        hclk, hresetn, hsel, hwrite, pix_rd, hreadyout, hresp;
    logic        irq, mem_req, mem_gnt, mem_rvalid, fetch_active_flag;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  blen, slow;
    logic [31:0] haddr, hwdata, hrdata, mem_addr, mem_rdata, pix_data, rd;
    int          n_fail, samples_checked;

    dff_fetch #(.FIFO_AW(5)) u_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_gnt(mem_gnt),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .pix_rd(pix_rd),
        .pix_data(pix_data), .fetch_active_flag(fetch_active_flag));
    dff_mem_model u_mem (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req),
        .mem_addr(mem_addr), .blen(blen), .slow(slow), .mem_gnt(mem_gnt),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

    always #25 hclk = ~hclk;

    task automatic final_report();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("Error at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // one rising edge with hready high, bounded
    task automatic edge_rdy();
        int i;
        i = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            i++;
            if (i > 50) begin
                n_fail++;
                final_report();
            end
            @(posedge hclk);
        end
    endtask
    // single word transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        edge_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        edge_rdy();
        rd = hrdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    // poll a status bit until it reads v; a hang ends the run
    task automatic wait_bit(input int b, input logic v);
        int i;
        i = 0;
        xfer(1'b0, DFF_OFS_STAT, 32'h0);
        while (rd[b] !== v) begin
            i++;
            if (i > 200) begin
                n_fail++;
                final_report();
            end
            xfer(1'b0, DFF_OFS_STAT, 32'h0);
        end
    endtask
    // pop one word; it is registered at the edge that takes pix_rd
    task automatic pix_pop(input logic [31:0] e, input logic c);
        if (c) begin
            wait_bit(DFF_ST_EMPTY, 1'b0);
        end
        pix_rd <= 1'b1;
        @(posedge hclk);
        pix_rd <= 1'b0;
        @(posedge hclk);
        if (c) begin
            chk(pix_data, e);
        end
    endtask

    initial begin
        {hclk, hresetn, hsel, hwrite, pix_rd, htrans} = '0;
        {haddr, hwdata, n_fail, samples_checked} = '0;
        hsize = 3'h2;
        blen = 4'hF;
        slow = 4'h0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(DFF_OFS_CFG, 32'hFFFF_FFFF, DFF_RST_CFG);
        xfer(1'b1, 8'h20, 32'hFFFF_FFFF);
        rchk(8'h20, 32'hFFFF_FFFF, 32'h0);
        // aligned base one burst short of a 1-Kbyte line; fifo fills up
        xfer(1'b1, DFF_OFS_CFG, 32'h0000_000F);
        xfer(1'b1, DFF_OFS_BASE, 32'h0000_03C0);
        xfer(1'b1, DFF_OFS_SIZE, 32'h0000_0020);
        xfer(1'b1, DFF_OFS_CTRL, 32'h0000_0003);
        wait_bit(DFF_ST_FULL, 1'b1);
        for (int i = 0; i < 32; i++) begin
            pix_pop(32'h3C0 + 32'(i * 4), 1'b1);
        end
        // recovery: power off, disable, wait idle, reset, power on
        xfer(1'b1, DFF_OFS_CTRL, 32'h0000_0001);
        xfer(1'b1, DFF_OFS_CTRL, 32'h0000_0000);
        wait_bit(DFF_ST_ACTIVE, 1'b0);
        xfer(1'b1, DFF_OFS_CTRL, 32'h0000_0004);
        xfer(1'b1, DFF_OFS_CTRL, 32'h0000_0002);
        rchk(DFF_OFS_STAT, 32'h2, 32'h2);
        rchk(DFF_OFS_ADDR, 32'hFFFF_FFFF, 32'h3C0);
        // pop while empty, then check it masked, unmask and clear the event
        pix_pop(32'h0, 1'b0);
        rchk(DFF_OFS_IRQS, 32'h1, 32'h1);
        rchk(DFF_OFS_IRQS, 32'h2, 32'h2);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, DFF_OFS_IRQM, 32'h0000_0001);
        @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        xfer(1'b1, DFF_OFS_IRQS, 32'h0000_0003);
        @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        rchk(DFF_OFS_IRQS, 32'h3, 32'h0);
        // packed mode, 4-word bursts from a pixel start, slow memory
        blen <= 4'h3;
        slow <= 4'h5;
        xfer(1'b1, DFF_OFS_CFG, 32'h0000_0103);
        xfer(1'b1, DFF_OFS_BASE, 32'h0000_0030);
        xfer(1'b1, DFF_OFS_SIZE, 32'h0000_0008);
        xfer(1'b1, DFF_OFS_CTRL, 32'h0000_0003);
        for (int i = 0; i < 4; i++) begin
            pix_pop(32'h30 + 32'(i * 4), 1'b1);
        end
        // fetch restart with power kept on: the old words come out first
        xfer(1'b1, DFF_OFS_CTRL, 32'h0000_0002);
        wait_bit(DFF_ST_ACTIVE, 1'b0);
        xfer(1'b1, DFF_OFS_CTRL, 32'h0000_0003);
        for (int i = 0; i < 8; i++) begin
            pix_pop((i < 4 ? 32'h40 : 32'h20) + 32'(i * 4), 1'b1);
        end
        // full recovery order empties the fifo of the leftover words
        rchk(DFF_OFS_STAT, 32'h2, 32'h0);
        xfer(1'b1, DFF_OFS_CTRL, 32'h0000_0001);
        xfer(1'b1, DFF_OFS_CTRL, 32'h0000_0000);
        wait_bit(DFF_ST_ACTIVE, 1'b0);
        xfer(1'b1, DFF_OFS_CTRL, 32'h0000_0006);
        rchk(DFF_OFS_STAT, 32'h2, 32'h2);
        final_report();
    end
endmodule
`default_nettype wire
